// ---- rtl/dfd_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dfd_decoder_regs.svh"

module dfd_decoder (
	input  wire logic                   clk,
	input  wire logic                   rst,
	input  wire logic                   fetch_valid,
	input  wire logic            [23:0] fetch_word,
	output logic                        fetch_ready,
	input  wire logic                   ex_redirect,
	output logic                        dec_valid,
	output logic                        dec_nop,
	output logic                        dec_dbl,
	output dfd_pkg::dfd_group_t         dec_group,
	output dfd_pkg::dfd_form_t          dec_form,
	output logic                  [7:0] dec_opcode,
	output logic                        dec_byte,
	output logic                  [3:0] base_source_register,
	output logic                  [3:0] second_source_register,
	output logic                  [1:0] src_mode,
	output logic                  [3:0] destination_register,
	output logic                  [1:0] dst_mode,
	output logic                        dst_en,
	output logic                 [12:0] file_addr,
	output logic                        file_to_default_working_register,
	output logic                  [3:0] bit_num,
	output logic                        bit_from_reg,
	output logic                 [15:0] literal,
	output logic                        acc_sel,
	output logic                  [3:0] mul_a,
	output logic                  [3:0] mul_b,
	output logic                  [3:0] x_pf_reg,
	output logic                  [1:0] x_pf_mode,
	output logic                  [3:0] x_pf_dst,
	output logic                  [3:0] y_pf_reg,
	output logic                  [1:0] y_pf_mode,
	output logic                  [3:0] y_pf_dst,
	output logic                        awb_en,
	output logic                  [3:0] awb_reg,
	output logic                        shift_from_reg,
	output logic                  [3:0] shift_amount_register,
	output logic                 [22:0] prog_addr,
	output logic                  [1:0] tbl_mode
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		dfd_pkg::dfd_state_t st;
		logic                vld;
		logic                nop;
		logic                dbl;
		dfd_pkg::dfd_group_t grp;
		dfd_pkg::dfd_form_t  form;
		logic [7:0]          op;
		logic                byte_m;
		logic [3:0]          base;
		logic [3:0]          src;
		logic [1:0]          smode;
		logic [3:0]          dst;
		logic [1:0]          dmode;
		logic                dst_en;
		logic [12:0]         faddr;
		logic                f_to_w;
		logic [3:0]          bitn;
		logic                bit_reg;
		logic [15:0]         lit;
		logic                acc;
		logic [3:0]          mula;
		logic [3:0]          mulb;
		logic [3:0]          xreg;
		logic [1:0]          xmode;
		logic [3:0]          xdst;
		logic [3:0]          yreg;
		logic [1:0]          ymode;
		logic [3:0]          ydst;
		logic                awb;
		logic                sh_reg;
		logic [3:0]          shreg;
		logic [22:0]         paddr;
		logic [1:0]          tmode;
	} dfd_main_t;

	dfd_main_t q, d;

	logic                [23:0] first_word;
	logic                 [7:0] op_sel;
	dfd_pkg::dfd_group_t        grp_w;
	dfd_pkg::dfd_form_t         form_w;
	logic                       dbl_w;
	logic                       pc_chg_w;
	logic                       take_first;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Register from a bank base plus a small selector
	function automatic logic [3:0] wsel(input logic [3:0] bank, input logic [1:0] sel);
		wsel = 4'(bank + {2'b00, sel}); // RQ17
	endfunction

	// Multiplier pair table; the last two codes are squares
	function automatic logic [7:0] mpair(input logic [2:0] code);
		case (code)
			3'h0:    mpair = 8'h45;
			3'h1:    mpair = 8'h46;
			3'h2:    mpair = 8'h47;
			3'h3:    mpair = 8'h56;
			3'h4:    mpair = 8'h57;
			3'h5:    mpair = 8'h67;
			3'h6:    mpair = 8'h44;
			default: mpair = 8'h55;
		endcase
	endfunction

	// Field steering for one instruction; w2 matters only for double words
	function automatic dfd_main_t decode(
		input dfd_main_t           cur,
		input logic         [23:0] w,
		input logic         [23:0] w2,
		input dfd_pkg::dfd_group_t g,
		input dfd_pkg::dfd_form_t  f,
		input logic                two
	);
		dfd_main_t r;
		logic [7:0] op;
		logic [7:0] mp;
		r        = '0;
		r.st     = cur.st;
		op       = w[23:16]; // RQ3
		mp       = mpair(w[14:12]);
		r.vld    = 1'b1;
		r.dbl    = two; // RQ13
		r.grp    = g;
		r.form   = f;
		r.op     = op;
		r.byte_m = op[0];
		case (f)
			dfd_pkg::DFD_FM_DEFAULT_WORKING_REGISTER, dfd_pkg::DFD_FM_TBL: begin
				r.base   = w[`DFD_BASE_LSB +: 4]; // RQ5
				r.dmode  = w[`DFD_DMODE_LSB +: 2];
				r.dst    = w[`DFD_DST_LSB +: 4];
				r.smode  = w[`DFD_SMODE_LSB +: 2];
				r.src    = w[`DFD_SRC_LSB +: 4];
				r.dst_en = 1'b1;
				if (f == dfd_pkg::DFD_FM_TBL) begin
					r.tmode = w[`DFD_TMODE_LSB +: 2]; // RQ12
					r.base  = 4'h0;
				end
			end
			dfd_pkg::DFD_FM_FILE: begin
				r.faddr  = w[12:0]; // RQ6
				r.f_to_w = w[`DFD_FDIR_BIT];
				r.dst_en = w[`DFD_FDIR_BIT];
				r.dst    = `DFD_DEFAULT_WORKING_REGISTER_DFLT;
			end
			dfd_pkg::DFD_FM_BIT_W: begin
				r.bit_reg = op[2]; // RQ7
				r.base    = op[2] ? w[`DFD_BASE_LSB +: 4] : 4'h0;
				r.bitn    = op[2] ? 4'h0 : w[`DFD_BASE_LSB +: 4];
				r.smode   = w[`DFD_SMODE_LSB +: 2];
				r.src     = w[`DFD_SRC_LSB +: 4];
			end
			dfd_pkg::DFD_FM_BIT_F: begin
				r.faddr = w[12:0]; // RQ7
				r.bitn  = {w[15:13], op[0]};
			end
			dfd_pkg::DFD_FM_MOV_W: begin
				r.lit    = {4'h0, w[15:4]}; // RQ8
				r.dst    = w[3:0];
				r.dst_en = 1'b1;
			end
			dfd_pkg::DFD_FM_MOV_F: begin
				r.faddr = w[12:0]; // RQ8
				r.lit   = {13'h0000, w[15:13]};
			end
			dfd_pkg::DFD_FM_ALU_D: begin
				r.base   = w[`DFD_BASE_LSB +: 4]; // RQ9
				r.dmode  = w[`DFD_DMODE_LSB +: 2];
				r.dst    = w[`DFD_DST_LSB +: 4];
				r.lit    = {10'h000, w[5:0]};
				r.dst_en = 1'b1;
			end
			dfd_pkg::DFD_FM_ALU_S: begin
				r.base = w[`DFD_BASE_LSB +: 4]; // RQ9
				r.lit  = {6'h00, w[9:0]};
			end
			dfd_pkg::DFD_FM_MAC: begin
				r.acc   = w[`DFD_ACC_BIT]; // RQ10
				r.mula  = mp[7:4];
				r.mulb  = mp[3:0];
				r.xreg  = wsel(`DFD_XPF_BASE, w[11:10]);
				r.xmode = w[9:8];
				r.yreg  = wsel(`DFD_YPF_BASE, w[7:6]);
				r.ymode = w[5:4];
				r.xdst  = wsel(`DFD_PFD_BASE, w[3:2]);
				r.ydst  = wsel(`DFD_PFD_BASE, w[1:0]);
				r.awb   = op[0];
			end
			dfd_pkg::DFD_FM_DSP: begin
				r.acc    = w[`DFD_ACC_BIT]; // RQ11
				r.sh_reg = op[1];
				r.shreg  = op[1] ? w[`DFD_SHREG_LSB +: 4] : 4'h0;
				r.lit    = op[1] ? 16'h0000 : {{10{w[13]}}, w[`DFD_SHLIT_LSB +: 6]};
				r.smode  = w[`DFD_SMODE_LSB +: 2];
				r.src    = w[`DFD_SRC_LSB +: 4];
			end
			dfd_pkg::DFD_FM_BRA: begin
				r.lit = w[15:0]; // RQ12
			end
			dfd_pkg::DFD_FM_JUMP: begin
				r.paddr = {w2[6:0], w[15:1], 1'b0}; // RQ12 RQ13
			end
			dfd_pkg::DFD_FM_DO: begin
				r.lit   = {2'b00, w[13:0]}; // RQ13
				r.paddr = {7'h00, w2[15:0]};
			end
			dfd_pkg::DFD_FM_RET: begin
				r.lit = 16'h0000;
			end
			default: begin
				r.nop = 1'b1; // RQ14
			end
		endcase
		decode = r;
	endfunction

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	// Opcode comes from the held first word while the second is awaited
	assign op_sel     = (q.st == dfd_pkg::DFD_ST_WAIT2) ? first_word[23:16] : fetch_word[23:16];
	assign take_first = (q.st == dfd_pkg::DFD_ST_ISSUE) && fetch_valid && !ex_redirect && dbl_w;

	dfd_group_decode u_grp (
		.opcode (op_sel),
		.group  (grp_w),
		.form   (form_w),
		.dbl    (dbl_w),
		.pc_chg (pc_chg_w)
	);

	dfd_word_join u_join (
		.clk        (clk),
		.rst        (rst),
		.load       (take_first),
		.word_in    (fetch_word),
		.first_word (first_word)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	// No word is taken in a bubble or while a redirect is pending; a redirect
	// during the second fetch waits, since the pair must issue together
	assign fetch_ready = (q.st == dfd_pkg::DFD_ST_WAIT2) ||
		((q.st == dfd_pkg::DFD_ST_ISSUE) && !ex_redirect);

	// Outputs other than the fixed awb_reg are zero unless an instruction or NOP cycle is issued
	always_comb begin
		d    = '0;
		d.st = q.st;
		case (q.st)
			dfd_pkg::DFD_ST_ISSUE: begin
				if (ex_redirect) begin
					d.vld = 1'b1; // RQ15
					d.nop = 1'b1;
				end else if (fetch_valid && dbl_w) begin
					d.st = dfd_pkg::DFD_ST_WAIT2; // RQ2 RQ16
				end else if (fetch_valid) begin
					d = decode(q, fetch_word, 24'h000000, grp_w, form_w, 1'b0); // RQ1
					d.st = pc_chg_w ? dfd_pkg::DFD_ST_BUBBLE : dfd_pkg::DFD_ST_ISSUE; // RQ15
				end
			end
			dfd_pkg::DFD_ST_WAIT2: begin
				if (fetch_valid) begin
					d = decode(q, first_word, fetch_word, grp_w, form_w, 1'b1); // RQ16
					d.st = pc_chg_w ? dfd_pkg::DFD_ST_BUBBLE : dfd_pkg::DFD_ST_ISSUE; // RQ15
				end
			end
			dfd_pkg::DFD_ST_BUBBLE: begin
				d.vld = 1'b1; // RQ15
				d.nop = 1'b1;
				d.st  = dfd_pkg::DFD_ST_ISSUE;
			end
			default: begin
				d.st = dfd_pkg::DFD_ST_ISSUE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign dec_valid              = q.vld;
	assign dec_nop                = q.nop;
	assign dec_dbl                = q.dbl;
	assign dec_group              = q.grp;
	assign dec_form               = q.form;
	assign dec_opcode             = q.op;
	assign dec_byte               = q.byte_m;
	assign base_source_register   = q.base;
	assign second_source_register = q.src;
	assign src_mode               = q.smode;
	assign destination_register   = q.dst;
	assign dst_mode               = q.dmode;
	assign dst_en                 = q.dst_en;
	assign file_addr              = q.faddr;
	assign file_to_default_working_register           = q.f_to_w;
	assign bit_num                = q.bitn;
	assign bit_from_reg           = q.bit_reg;
	assign literal                = q.lit;
	assign acc_sel                = q.acc;
	assign mul_a                  = q.mula;
	assign mul_b                  = q.mulb;
	assign x_pf_reg               = q.xreg;
	assign x_pf_mode              = q.xmode;
	assign x_pf_dst               = q.xdst;
	assign y_pf_reg               = q.yreg;
	assign y_pf_mode              = q.ymode;
	assign y_pf_dst               = q.ydst;
	assign awb_en                 = q.awb;
	assign awb_reg                = `DFD_AWB_REG; // Fixed write-back register
	assign shift_from_reg         = q.sh_reg;
	assign shift_amount_register  = q.shreg;
	assign prog_addr              = q.paddr;
	assign tbl_mode               = q.tmode;

endmodule
`default_nettype wire

// ---- rtl/dfd_decoder_regs.svh ----
// Functional notes
// [RQ1] An ordinary instruction is one 24-bit word, decoded alone.
// [RQ2] Exactly three opcodes take two words; the first is held until the second arrives.
// [RQ3] The 8-bit opcode selects the type; remaining bits are operand fields.
// [RQ4] Every instruction falls in word, bit, literal, DSP or control group.
// [RQ5] W-register word ops give base, modified source and modified destination.
// [RQ6] File-register ops give a file address and a file-or-W0 selector.
// [RQ7] Bit ops target a W or file register; bit from literal or base.
// [RQ8] Literal moves give a literal and a W or file target.
// [RQ9] Literal ALU ops give base, literal, and destination only when separate.
// [RQ10] MAC ops give accumulator, multiplier pair, X/Y prefetch, write-back.
// [RQ11] Other DSP ops give accumulator, modified operand, register or literal shift.
// [RQ12] Control ops give a program address and, for tables, a mode.
// [RQ13] Double words carry 48 bits; second word's upper 8 bits are zero.
// [RQ14] A lone second word decodes as a side-effect-free no-operation.
// [RQ15] Single words take one cycle; taken or PC-changing ones add a NOP cycle.
// [RQ16] Double-word instructions take two cycles.
// [RQ17] W fields select one of 16 working registers.
`ifndef DFD_DECODER_REGS_SVH
`define DFD_DECODER_REGS_SVH

// ----------------------------------------
// Word layout
// ----------------------------------------
`define DFD_WORD_W      24
`define DFD_OP_LSB      16
`define DFD_BASE_LSB    12
`define DFD_DMODE_LSB   10
`define DFD_DST_LSB     6
`define DFD_SMODE_LSB   4
`define DFD_SRC_LSB     0
`define DFD_FDIR_BIT    13
`define DFD_ACC_BIT     15
`define DFD_SHREG_LSB   10
`define DFD_SHLIT_LSB   8
`define DFD_TMODE_LSB   14

// ----------------------------------------
// Opcodes and fixed registers
// ----------------------------------------
`define DFD_OP_NOP      8'h00
`define DFD_OP_BRA      8'h01
`define DFD_OP_CALL     8'h02
`define DFD_OP_GOTO     8'h04
`define DFD_OP_RET      8'h06
`define DFD_OP_DO       8'h08
`define DFD_OP_TBLRD    8'h0A
`define DFD_OP_TBLWR    8'h0B
`define DFD_DEFAULT_WORKING_REGISTER_DFLT   4'h0
`define DFD_XPF_BASE    4'h8
`define DFD_YPF_BASE    4'hA
`define DFD_PFD_BASE    4'h4
`define DFD_AWB_REG     4'hD
`define DFD_RST_ZERO    1'b0

`endif

// ---- rtl/dfd_group_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dfd_decoder_regs.svh"

// Opcode to group, layout and sequencing class
module dfd_group_decode (
	input  wire logic             [7:0] opcode,
	output dfd_pkg::dfd_group_t         group,
	output dfd_pkg::dfd_form_t          form,
	output logic                        dbl,
	output logic                        pc_chg
);

	// Top three bits pick the group, low bits the layout variant
	always_comb begin
		group  = dfd_pkg::DFD_GRP_CTRL;
		form   = dfd_pkg::DFD_FM_NOP;
		dbl    = 1'b0;
		pc_chg = 1'b0;
		case (opcode[7:5]) // RQ3 RQ4
			3'h1: begin
				group = dfd_pkg::DFD_GRP_WORD;
				form  = dfd_pkg::DFD_FM_DEFAULT_WORKING_REGISTER;
			end
			3'h2: begin
				group = dfd_pkg::DFD_GRP_WORD;
				form  = dfd_pkg::DFD_FM_FILE;
			end
			3'h3: begin
				group = dfd_pkg::DFD_GRP_BIT;
				form  = opcode[1] ? dfd_pkg::DFD_FM_BIT_F : dfd_pkg::DFD_FM_BIT_W;
			end
			3'h4: begin
				group = dfd_pkg::DFD_GRP_LIT;
				form  = opcode[1] ? dfd_pkg::DFD_FM_MOV_F : dfd_pkg::DFD_FM_MOV_W;
			end
			3'h5: begin
				group = dfd_pkg::DFD_GRP_LIT;
				form  = opcode[1] ? dfd_pkg::DFD_FM_ALU_S : dfd_pkg::DFD_FM_ALU_D;
			end
			3'h6: begin
				group = dfd_pkg::DFD_GRP_DSP;
				form  = dfd_pkg::DFD_FM_MAC;
			end
			3'h7: begin
				group = dfd_pkg::DFD_GRP_DSP;
				form  = dfd_pkg::DFD_FM_DSP;
			end
			default: begin
				case (opcode)
					`DFD_OP_BRA:   form = dfd_pkg::DFD_FM_BRA;
					`DFD_OP_CALL,
					`DFD_OP_GOTO: begin
						form   = dfd_pkg::DFD_FM_JUMP;
						dbl    = 1'b1; // RQ2
						pc_chg = 1'b1;
					end
					`DFD_OP_DO: begin
						form = dfd_pkg::DFD_FM_DO;
						dbl  = 1'b1; // RQ2
					end
					`DFD_OP_TBLRD,
					`DFD_OP_TBLWR: form = dfd_pkg::DFD_FM_TBL;
					`DFD_OP_RET: begin
						form   = dfd_pkg::DFD_FM_RET;
						pc_chg = 1'b1; // RQ15
					end
					default:      form = dfd_pkg::DFD_FM_NOP; // RQ14
				endcase
			end
		endcase
	end

endmodule
`default_nettype wire

// ---- rtl/dfd_pkg.sv ----
package dfd_pkg;

	// Instruction groups
	typedef enum logic [2:0] {
		DFD_GRP_WORD,
		DFD_GRP_BIT,
		DFD_GRP_LIT,
		DFD_GRP_DSP,
		DFD_GRP_CTRL
	} dfd_group_t;

	// Operand layouts
	typedef enum logic [3:0] {
		DFD_FM_NOP,
		DFD_FM_DEFAULT_WORKING_REGISTER,
		DFD_FM_FILE,
		DFD_FM_BIT_W,
		DFD_FM_BIT_F,
		DFD_FM_MOV_W,
		DFD_FM_MOV_F,
		DFD_FM_ALU_D,
		DFD_FM_ALU_S,
		DFD_FM_MAC,
		DFD_FM_DSP,
		DFD_FM_BRA,
		DFD_FM_JUMP,
		DFD_FM_DO,
		DFD_FM_TBL,
		DFD_FM_RET
	} dfd_form_t;

	// Issue sequencer
	typedef enum logic [1:0] {
		DFD_ST_ISSUE,
		DFD_ST_WAIT2,
		DFD_ST_BUBBLE
	} dfd_state_t;

endpackage

// ---- rtl/dfd_word_join.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dfd_decoder_regs.svh"

// Holds the first word of a double-word instruction
module dfd_word_join (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        load,
	input  wire logic [23:0] word_in,
	output logic      [23:0] first_word
);

	typedef struct packed {
		logic [23:0] first;
	} dfd_join_t;

	dfd_join_t q, d;

	// Capture only on the first half, so the second fetch cannot disturb it
	always_comb begin
		d = q;
		if (load) begin
			d.first = word_in; // RQ2
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign first_word = q.first;

endmodule
`default_nettype wire

// ---- tb/dfd_decoder_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Decoder port checker
// ----------------------------------------
module dfd_decoder_chk (
	input wire logic                clk,
	input wire logic                rst,
	input wire logic                fetch_valid,
	input wire logic         [23:0] fetch_word,
	input wire logic                fetch_ready,
	input wire logic                dec_valid,
	input wire logic                dec_nop,
	input wire logic                dec_dbl,
	input wire dfd_pkg::dfd_group_t dec_group,
	input wire logic          [7:0] dec_opcode,
	input wire logic         [22:0] prog_addr,
	input wire logic          [3:0] awb_reg
);
	logic take;
	logic real_op;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Handshake and issued-instruction qualifiers
	assign take    = fetch_valid && fetch_ready;
	assign real_op = dec_valid && !dec_nop;

	chk_single_issue: assert property (
		take && fetch_word[23:21] != 3'b000
		|=> real_op && dec_opcode == $past(fetch_word[23:16]))
		else $error("single word not issued one cycle later");
	chk_first_silent: assert property (
		take && (fetch_word[23:16] == 8'h02 || fetch_word[23:16] == 8'h04 ||
		fetch_word[23:16] == 8'h08) |=> !dec_valid)
		else $error("first word of a pair issued alone");
	chk_jump_bubble: assert property (
		real_op && (dec_opcode == 8'h02 || dec_opcode == 8'h04 || dec_opcode == 8'h06)
		|-> !fetch_ready ##1 (dec_valid && dec_nop))
		else $error("flow change without a following idle cycle");
	chk_dbl_class: assert property (
		dec_valid && dec_dbl |-> dec_group == dfd_pkg::DFD_GRP_CTRL &&
		(dec_opcode == 8'h02 || dec_opcode == 8'h04 || dec_opcode == 8'h08))
		else $error("double flag on a single-word opcode");
	chk_nop_plain: assert property (
		dec_valid && dec_nop |-> !dec_dbl && prog_addr == 23'h000000)
		else $error("idle cycle carries side effects");
	chk_word_group: assert property (
		real_op && dec_opcode[7:5] inside {3'b001, 3'b010}
		|-> dec_group == dfd_pkg::DFD_GRP_WORD)
		else $error("word opcode in wrong group");
	chk_lit_group: assert property (
		real_op && dec_opcode[7:6] == 2'b10 |-> dec_group == dfd_pkg::DFD_GRP_LIT)
		else $error("literal opcode in wrong group");
	chk_dsp_group: assert property (
		real_op && dec_opcode[7:6] == 2'b11 |-> dec_group == dfd_pkg::DFD_GRP_DSP)
		else $error("signal processing opcode in wrong group");
	chk_awb_fixed: assert property (
		awb_reg == 4'hD)
		else $error("write-back register not fixed");
endmodule

bind dfd_decoder dfd_decoder_chk u_chk (.clk, .rst, .fetch_valid, .fetch_word, .fetch_ready,
	.dec_valid, .dec_nop, .dec_dbl, .dec_group, .dec_opcode, .prog_addr, .awb_reg);
`default_nettype wire

// ---- tb/dfd_fetch_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Program fetch model
// ----------------------------------------
module dfd_fetch_model (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        fetch_ready,
	input  wire logic        slow,
	output var  logic        fetch_valid,
	output var  logic [23:0] fetch_word
);
	logic [23:0] q[$];
	logic        took;
	logic        gap;

	// Quiet start
	initial begin
		fetch_valid = 1'b0;
		fetch_word  = 24'h000000;
		took        = 1'b0;
	end

	// Note acceptance at the edge where the decoder samples it
	always @(posedge clk) begin
		took = fetch_valid && fetch_ready && !rst;
	end

	// Offer between edges; a word stays put until taken, slow mode idles once per word
	always @(negedge clk) begin
		if (took) begin
			void'(q.pop_front());
		end
		gap = took && slow;
		if (q.size() > 0 && !gap) begin
			fetch_valid = 1'b1;
			fetch_word  = q[0];
		end else begin
			fetch_valid = 1'b0;
			fetch_word  = ~fetch_word; // Idle bus must not look like a held word
		end
	end

	task automatic push(input logic [23:0] w);
		q.push_back(w);
	endtask
endmodule
`default_nettype wire

// ---- tb/test_dsc_instruction_format_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Decoder testbench
// ----------------------------------------
module test_dsc_instruction_format_decoder;
	logic                clk, rst, fetch_valid, fetch_ready, ex_redirect, slow;
	logic         [23:0] fetch_word;
	logic                dec_valid, dec_nop, dec_dbl, dec_byte, dst_en, file_to_default_working_register;
	logic                bit_from_reg, acc_sel, awb_en, shift_from_reg;
	dfd_pkg::dfd_group_t dec_group;
	dfd_pkg::dfd_form_t  dec_form;
	logic          [7:0] dec_opcode;
	logic          [3:0] base_source_register, second_source_register, destination_register;
	logic          [3:0] bit_num, mul_a, mul_b, x_pf_reg, y_pf_dst, awb_reg, x_pf_dst, y_pf_reg;
	logic          [3:0] shift_amount_register;
	logic          [1:0] src_mode, dst_mode, tbl_mode, x_pf_mode, y_pf_mode;
	logic         [12:0] file_addr;
	logic         [15:0] literal;
	logic         [22:0] prog_addr;
	int                  num_errors, checked;

	dfd_fetch_model u_fetch (.clk, .rst, .fetch_ready, .slow, .fetch_valid, .fetch_word);

	dfd_decoder dut (
		.clk, .rst, .fetch_valid, .fetch_word, .fetch_ready, .ex_redirect,
		.dec_valid, .dec_nop, .dec_dbl, .dec_group, .dec_form, .dec_opcode, .dec_byte,
		.base_source_register, .second_source_register, .src_mode, .destination_register,
		.dst_mode, .dst_en, .file_addr, .file_to_default_working_register, .bit_num, .bit_from_reg, .literal,
		.acc_sel, .mul_a, .mul_b, .x_pf_reg, .x_pf_mode, .x_pf_dst, .y_pf_reg,
		.y_pf_mode, .y_pf_dst, .awb_en, .awb_reg, .shift_from_reg, .shift_amount_register,
		.prog_addr, .tbl_mode
	);

	task automatic check(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			num_errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic give_verdict();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Next issue slot, sampled mid-cycle; bounded so a stuck decoder is caught
	task automatic next_issue();
		for (int i = 0; i < 20; i++) begin
			@(negedge clk);
			if (dec_valid === 1'b1) return;
		end
		num_errors++;
		$display("MISMATCH t=%0t no issue", $time);
	endtask

	// Register and file operands, back to back
	task automatic t_word();
		u_fetch.push(24'h213A5F);
		u_fetch.push(24'h403ABC);
		u_fetch.push(24'h411ABC);
		next_issue();
		check({dec_opcode, dec_byte}, 9'h043);
		check(dec_group, dfd_pkg::DFD_GRP_WORD);
		check(base_source_register, 4'h3);
		check({dst_mode, destination_register}, 6'h29);
		check({src_mode, second_source_register}, 6'h1F);
		next_issue();
		check({file_to_default_working_register, dst_en, destination_register}, 6'h30);
		check(file_addr, 13'h1ABC);
		next_issue();
		check({file_to_default_working_register, dst_en, file_addr}, 15'h1ABC);
	endtask

	// Redirect refuses a waiting word and inserts an idle cycle
	task automatic t_redirect();
		u_fetch.push(24'h210000);
		ex_redirect = 1'b1;
		#1;
		check(fetch_ready, 1'b0);
		@(negedge clk);
		ex_redirect = 1'b0;
		check({dec_valid, dec_nop}, 2'h3);
		next_issue();
		check({dec_nop, dec_opcode}, 9'h021);
	endtask

	// Bit selection from literal, from register, and on a file register
	task automatic t_bit();
		u_fetch.push(24'h605000);
		u_fetch.push(24'h647000);
		u_fetch.push(24'h63A123);
		next_issue();
		check(dec_group, dfd_pkg::DFD_GRP_BIT);
		check({bit_from_reg, bit_num}, 5'h05);
		next_issue();
		check({bit_from_reg, base_source_register}, 5'h17);
		next_issue();
		check({bit_num, file_addr}, 17'h16123);
	endtask

	// Literal moves and literal arithmetic with and without separate destination
	task automatic t_lit();
		u_fetch.push(24'h80ABC5);
		u_fetch.push(24'hA07A85);
		u_fetch.push(24'hA273FF);
		u_fetch.push(24'h82A123);
		next_issue();
		check(dec_group, dfd_pkg::DFD_GRP_LIT);
		check(dec_form, dfd_pkg::DFD_FM_MOV_W);
		check({literal, destination_register}, 20'h0ABC5);
		next_issue();
		check({base_source_register, dst_mode, destination_register}, 10'h1EA);
		check({dst_en, literal}, 17'h10005);
		next_issue();
		check({dst_en, base_source_register, literal}, 21'h703FF);
		next_issue();
		check(dec_form, dfd_pkg::DFD_FM_MOV_F);
		check({literal, file_addr}, 29'h000A123);
	endtask

	// Every multiplier pair code with a slow fetch, then shift forms
	task automatic t_dsp();
		logic [7:0][7:0] pairs;
		pairs = {8'h55, 8'h44, 8'h67, 8'h57, 8'h56, 8'h47, 8'h46, 8'h45};
		slow  = 1'b1;
		for (int c = 0; c < 8; c++) begin
			u_fetch.push({8'hC1, 1'b1, c[2:0], 12'h7A7});
		end
		for (int c = 0; c < 8; c++) begin
			next_issue();
			check({mul_a, mul_b}, pairs[c]);
			check({acc_sel, awb_en, x_pf_reg, y_pf_dst}, 10'h397);
			check({x_pf_mode, x_pf_dst, y_pf_reg, y_pf_mode}, 12'hD72);
			check(awb_reg, 4'hD);
		end
		slow = 1'b0;
		u_fetch.push(24'hE23C00);
		u_fetch.push(24'hE0A500);
		next_issue();
		check(dec_group, dfd_pkg::DFD_GRP_DSP);
		check({acc_sel, shift_from_reg, shift_amount_register}, 6'h1F);
		next_issue();
		check({acc_sel, shift_from_reg, literal}, 18'h2FFE5);
	endtask

	// Jumps, loop setup, lone second word, table modes, return
	task automatic t_ctrl();
		u_fetch.push(24'h021234);
		u_fetch.push(24'h000055);
		u_fetch.push(24'h083FFF);
		u_fetch.push(24'h00BEEF);
		u_fetch.push(24'h001111);
		u_fetch.push(24'h0AC000);
		u_fetch.push(24'h0B4000);
		u_fetch.push(24'h060000);
		u_fetch.push(24'h040010);
		u_fetch.push(24'h00007F);
		u_fetch.push(24'h01ABCD);
		next_issue();
		check({dec_dbl, dec_group, prog_addr}, 27'h6551234);
		next_issue();
		check({dec_nop, dec_dbl}, 2'h2);
		next_issue();
		check({dec_dbl, literal}, 17'h13FFF);
		check(prog_addr, 23'h00BEEF);
		next_issue();
		check({dec_nop, dec_dbl}, 2'h2);
		next_issue();
		check({dec_opcode, tbl_mode}, 10'h02B);
		next_issue();
		check({dec_opcode, tbl_mode}, 10'h02D);
		next_issue();
		check({dec_nop, dec_opcode}, 9'h006);
		next_issue();
		check(dec_nop, 1'b1);
		next_issue();
		check(dec_form, dfd_pkg::DFD_FM_JUMP);
		check({dec_dbl, prog_addr}, 24'hFF0010);
		next_issue();
		check({dec_nop, dec_dbl}, 2'h2);
		next_issue();
		check(dec_form, dfd_pkg::DFD_FM_BRA);
		check({dec_nop, literal}, 17'h0ABCD);
	endtask

	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Main sequence
	initial begin
		rst         = 1'b1;
		ex_redirect = 1'b0;
		slow        = 1'b0;
		num_errors  = 0;
		checked     = 0;
		repeat (2) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		t_word();
		t_redirect();
		t_bit();
		t_lit();
		t_dsp();
		t_ctrl();
		give_verdict();
	end

	// Watchdog: the run needs well under a hundred cycles
	initial begin
		#10000;
		num_errors++;
		give_verdict();
	end
endmodule
`default_nettype wire
